//--- common/fault_bank_regs.vh
// Register offsets, field positions, reset values and timing counts of the fault/resampler bank
`ifndef FAULT_BANK_REGS_VH
`define FAULT_BANK_REGS_VH

// Printed offsets are register indices (not all multiples of four)
`define ADDR_FAULT_SUMMARY_A     12'h05D
`define ADDR_FAULT_SUMMARY_B     12'h05E
`define ADDR_FAULT_SUMMARY_C     12'h05F
`define ADDR_DECIM_RATIO_HIGH    12'h060
`define ADDR_DECIM_RATIO_LOW     12'h061
`define ADDR_DECIM_FRACTION_HIGH 12'h062
`define ADDR_DECIM_FRACTION_LOW  12'h063
`define ADDR_RESAMPLER_LOAD_CTRL 12'h064
`define ADDR_IRQ_STATUS          12'h070
`define ADDR_IRQ_MASK            12'h071

// Field positions
`define GLOBAL_FAULT_BIT         5
`define INIT_DONE_BIT            4
`define LOAD_STROBE_BIT          0
`define LOAD_ORIGIN_BIT          7

// Reset values; the ratio high register holds only its 4-bit field
`define RST_DECIM_RATIO_HIGH     4'h0
`define RST_DECIM_RATIO_LOW      8'h80
`define RST_DECIM_FRACTION_HIGH  8'h00
`define RST_DECIM_FRACTION_LOW   8'h00
`define RST_LOAD_CTRL            8'h00

// Interrupt status bits
`define IRQ_FAULT_RISE_BIT       0
`define IRQ_INIT_DONE_BIT        1
`define IRQ_LOAD_DONE_BIT        2

// Fuse initialisation time in ns, and derived cycle count at 100 MHz
`define INIT_TIME_NS             1000
`define CLK_PERIOD_NS            10
`define INIT_CYCLES              ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- core/sync3.v
// Three-flop synchroniser with second/third agreement filter
`timescale 1ns/1ns
module sync3 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Asynchronous input and filtered result
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // Chain; first stage feeds only the second
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree, which rejects one-cycle glitches
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          sync_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule

//--- core/ratio_stage.v
// Staged and active copies of the resampler decimation ratio
`include "fault_bank_regs.vh"
`timescale 1ns/1ns
module ratio_stage #(
  parameter INT_W  = 12,
  parameter FRAC_W = 16
) (
  // Clock and reset
  input  wire              clk_in,
  input  wire              rst_in,
  // Staged values and load pulse
  input  wire [INT_W-1:0]  staged_int_in,
  input  wire [FRAC_W-1:0] staged_frac_in,
  input  wire              load_in,
  // Active values seen by the converter
  output reg  [INT_W-1:0]  active_int_out,
  output reg  [FRAC_W-1:0] active_frac_out,
  output reg               loaded_out
);

  // Active ratio only moves on a load, so partial register writes never reach the converter
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_int_out  <= {`RST_DECIM_RATIO_HIGH, `RST_DECIM_RATIO_LOW};
      active_frac_out <= {FRAC_W{1'b0}};
      loaded_out      <= 1'b0;
    end else begin
      loaded_out <= load_in;
      if (load_in) begin
        active_int_out  <= staged_int_in;
        active_frac_out <= staged_frac_in;
      end
    end
  end

endmodule

//--- core/fault_summary_bank.v
// Fault summary and resampler ratio register bank
//
// Behaviour
// - Bit 5 of all three summaries is high whenever any error flag is high.
// - Summary A bits 0..4 flag active errors of channels 0..4.
// - Summary B bits 0..2 flag channels 5..7; bit 3 general one, bit 4 general two.
// - Summary C bits 0..3 flag saturation pair registers 0/1, 2/3, 4/5, 6/7.
// - Summary C bit 4 goes high once fuse initialisation has finished.
// - Integer ratio is 12 bits: [11:8] in high low nibble, [7:0] in low.
// - Integer ratio low byte resets to 0x80, giving 128.
// - Fraction is 16 bits over high and low byte registers, both reset zero.
// - Setting load bit 0 moves staged ratio into the active converter.
// - Load bit 7 selects register bit or external update pin as load trigger.
`include "fault_bank_regs.vh"
`timescale 1ns/1ns
module fault_summary_bank #(
  parameter ADDR_W      = 12,
  parameter INIT_CYCLES = `INIT_CYCLES
) (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        SYS_RST_IN,
  // Register port
  input  wire [11:0] REG_ADDR_IN,
  input  wire [7:0]  REG_WDATA_IN,
  input  wire        REG_WR_IN,
  input  wire        REG_RD_IN,
  output reg  [7:0]  REG_RDATA_OUT,
  // Error sources from the device (same clock)
  input  wire [63:0] PER_CHANNEL_ERROR_REGISTER_IN,
  input  wire [7:0]  GENERAL_ERROR_REGISTER_ONE_IN,
  input  wire [7:0]  GENERAL_ERROR_REGISTER_TWO_IN,
  input  wire [31:0] PAIR_SATURATION_ERROR_REGISTER_IN,
  // External update pin (asynchronous)
  input  wire        EXT_UPDATE_IN,
  // Active ratio to the converter
  output wire [11:0] INTEGER_DECIMATION_RATIO_OUT,
  output wire [15:0] FRACTIONAL_DECIMATION_RATIO_OUT,
  output wire        RATIO_LOADED_OUT,
  output wire        INIT_DONE_OUT,
  // Interrupt
  output wire        IRQ_OUT
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Address match, used by both write and read decode
  function hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // ----------------------------------------------------------------
  // Fault locators
  // ----------------------------------------------------------------

  wire [7:0] channel_fault_locator;
  wire [3:0] pair_saturation_locator;
  wire       general_fault_group1_locator;
  wire       general_fault_group2_locator;
  wire       global_fault;

  // One OR-reduction per channel and per saturation pair
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ch
      assign channel_fault_locator[g] = |PER_CHANNEL_ERROR_REGISTER_IN[g*8 +: 8];
    end
    for (g = 0; g < 4; g = g + 1) begin : g_pair
      assign pair_saturation_locator[g] = |PAIR_SATURATION_ERROR_REGISTER_IN[g*8 +: 8];
    end
  endgenerate

  assign general_fault_group1_locator = |GENERAL_ERROR_REGISTER_ONE_IN;
  assign general_fault_group2_locator = |GENERAL_ERROR_REGISTER_TWO_IN;
  // Any individual flag anywhere raises the global fault
  assign global_fault = (|channel_fault_locator) | (|pair_saturation_locator)
                      | general_fault_group1_locator | general_fault_group2_locator;

  // ----------------------------------------------------------------
  // Fuse initialisation timer
  // ----------------------------------------------------------------

  // Last count before the done flag rises; 32 bits wide to match the parameter.
  // The counter is 16 bits, so fuse times beyond 65536 cycles are not supported.
  localparam [31:0] INIT_LAST = INIT_CYCLES - 1;

  reg [15:0] init_cnt_q;
  reg        init_done_q;

  // Counts out the fuse load time after reset release
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      init_cnt_q  <= 16'h0000;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 16'h0001;
      if ({16'h0000, init_cnt_q} >= INIT_LAST) begin
        init_done_q <= 1'b1;
      end
    end
  end

  assign INIT_DONE_OUT = init_done_q;

  // ----------------------------------------------------------------
  // Summary register images
  // ----------------------------------------------------------------

  wire [7:0] summary_a;
  wire [7:0] summary_b;
  wire [7:0] summary_c;

  // Upper two bits are reserved and read zero
  assign summary_a = {2'b00, global_fault, channel_fault_locator[4:0]};
  assign summary_b = {2'b00, global_fault, general_fault_group2_locator,
                      general_fault_group1_locator, channel_fault_locator[7:5]};
  assign summary_c = {2'b00, global_fault, init_done_q, pair_saturation_locator};

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------

  reg [3:0] ratio_high_q;
  reg [7:0] ratio_low_q;
  reg [7:0] fraction_high_q;
  reg [7:0] fraction_low_q;
  reg       load_origin_q;
  reg       load_strobe_q;
  reg [2:0] irq_status_q;
  reg [2:0] irq_mask_q;
  wire      wr_ratio_high;
  wire      wr_load;
  wire      wr_status;
  wire      load_pulse;
  wire      loaded;
  wire [2:0] irq_events;
  reg        global_fault_q;

  // Write decodes; the load and status ones are also needed outside the staging process
  assign wr_ratio_high = REG_WR_IN && hit(REG_ADDR_IN, `ADDR_DECIM_RATIO_HIGH);
  assign wr_load       = REG_WR_IN && hit(REG_ADDR_IN, `ADDR_RESAMPLER_LOAD_CTRL);
  assign wr_status     = REG_WR_IN && hit(REG_ADDR_IN, `ADDR_IRQ_STATUS);

  // Staging registers; summaries have no write path at all
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ratio_high_q    <= `RST_DECIM_RATIO_HIGH;
      ratio_low_q     <= `RST_DECIM_RATIO_LOW;
      fraction_high_q <= `RST_DECIM_FRACTION_HIGH;
      fraction_low_q  <= `RST_DECIM_FRACTION_LOW;
      load_origin_q   <= 1'b0;
      irq_mask_q      <= 3'h0;
    end else if (REG_WR_IN) begin
      if (wr_ratio_high) begin
        ratio_high_q <= REG_WDATA_IN[3:0];
      end
      if (hit(REG_ADDR_IN, `ADDR_DECIM_RATIO_LOW)) begin
        ratio_low_q <= REG_WDATA_IN;
      end
      if (hit(REG_ADDR_IN, `ADDR_DECIM_FRACTION_HIGH)) begin
        fraction_high_q <= REG_WDATA_IN;
      end
      if (hit(REG_ADDR_IN, `ADDR_DECIM_FRACTION_LOW)) begin
        fraction_low_q <= REG_WDATA_IN;
      end
      if (wr_load) begin
        load_origin_q <= REG_WDATA_IN[`LOAD_ORIGIN_BIT];
      end
      if (hit(REG_ADDR_IN, `ADDR_IRQ_MASK)) begin
        irq_mask_q <= REG_WDATA_IN[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Load trigger
  // ----------------------------------------------------------------

  wire ext_update_sync;
  reg  ext_update_q;

  sync3 #(
    .WIDTH (1)
  ) u_ext_sync (
    .clk_in   (CLK_IN),
    .rst_in   (SYS_RST_IN),
    .async_in (EXT_UPDATE_IN),
    .sync_out (ext_update_sync)
  );

  // Strobe bit self-clears after one cycle so each strobe write under register origin (bit 7 clear) loads exactly once
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      load_strobe_q <= 1'b0;
      ext_update_q  <= 1'b0;
    end else begin
      load_strobe_q <= wr_load && REG_WDATA_IN[`LOAD_STROBE_BIT]
                       && !REG_WDATA_IN[`LOAD_ORIGIN_BIT]
                       && !load_origin_q;
      ext_update_q  <= ext_update_sync;
    end
  end

  // Origin 0 takes the register strobe, origin 1 takes a rising edge of the pin
  assign load_pulse = load_origin_q ? (ext_update_sync && !ext_update_q)
                                    : load_strobe_q;

  ratio_stage #(
    .INT_W  (12),
    .FRAC_W (16)
  ) u_ratio (
    .clk_in          (CLK_IN),
    .rst_in          (SYS_RST_IN),
    .staged_int_in   ({ratio_high_q, ratio_low_q}),
    .staged_frac_in  ({fraction_high_q, fraction_low_q}),
    .load_in         (load_pulse),
    .active_int_out  (INTEGER_DECIMATION_RATIO_OUT),
    .active_frac_out (FRACTIONAL_DECIMATION_RATIO_OUT),
    .loaded_out      (loaded)
  );

  assign RATIO_LOADED_OUT = loaded;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------

  reg init_done_prev_q;

  // Events: fault rising, init finished, ratio loaded; each is a one-cycle pulse
  assign irq_events = {loaded,
                       init_done_q & ~init_done_prev_q,
                       global_fault & ~global_fault_q};

  // Set beats clear so an event in the clearing cycle survives
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      irq_status_q     <= 3'h0;
      global_fault_q   <= 1'b0;
      init_done_prev_q <= 1'b0;
    end else begin
      global_fault_q   <= global_fault;
      init_done_prev_q <= init_done_q;
      irq_status_q     <= (irq_status_q & ~(wr_status ? REG_WDATA_IN[2:0] : 3'h0)) | irq_events;
    end
  end

  assign IRQ_OUT = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  reg [7:0] rd_mux;

  // Unmapped addresses read zero
  always @* begin
    rd_mux = 8'h00;
    if (hit(REG_ADDR_IN, `ADDR_FAULT_SUMMARY_A)) begin
      rd_mux = summary_a;
    end else if (hit(REG_ADDR_IN, `ADDR_FAULT_SUMMARY_B)) begin
      rd_mux = summary_b;
    end else if (hit(REG_ADDR_IN, `ADDR_FAULT_SUMMARY_C)) begin
      rd_mux = summary_c;
    end else if (hit(REG_ADDR_IN, `ADDR_DECIM_RATIO_HIGH)) begin
      rd_mux = {4'h0, ratio_high_q};
    end else if (hit(REG_ADDR_IN, `ADDR_DECIM_RATIO_LOW)) begin
      rd_mux = ratio_low_q;
    end else if (hit(REG_ADDR_IN, `ADDR_DECIM_FRACTION_HIGH)) begin
      rd_mux = fraction_high_q;
    end else if (hit(REG_ADDR_IN, `ADDR_DECIM_FRACTION_LOW)) begin
      rd_mux = fraction_low_q;
    end else if (hit(REG_ADDR_IN, `ADDR_RESAMPLER_LOAD_CTRL)) begin
      rd_mux = {load_origin_q, 6'h00, load_strobe_q};
    end else if (hit(REG_ADDR_IN, `ADDR_IRQ_STATUS)) begin
      rd_mux = {5'h00, irq_status_q};
    end else if (hit(REG_ADDR_IN, `ADDR_IRQ_MASK)) begin
      rd_mux = {5'h00, irq_mask_q};
    end
  end

  // Read data registered, valid the cycle after the strobe;
  // zero outside that slot so a stale value never looks like an answer
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= rd_mux;
    end else begin
      REG_RDATA_OUT <= 8'h00;
    end
  end

endmodule

//--- verification/fault_bank_sva.sv
// Assertion checker for the fault summary and resampler register bank
`timescale 1ns/1ns
`include "fault_bank_regs.vh"
module fault_bank_sva #(
  parameter INIT_CYCLES = `INIT_CYCLES
) (
  // Clock and reset
  input wire        CLK_IN,
  input wire        SYS_RST_IN,
  // Register port
  input wire [11:0] REG_ADDR_IN,
  input wire [7:0]  REG_WDATA_IN,
  input wire        REG_WR_IN,
  input wire        REG_RD_IN,
  input wire [7:0]  REG_RDATA_OUT,
  // Error sources
  input wire [63:0] PER_CHANNEL_ERROR_REGISTER_IN,
  input wire [7:0]  GENERAL_ERROR_REGISTER_ONE_IN,
  input wire [7:0]  GENERAL_ERROR_REGISTER_TWO_IN,
  input wire [31:0] PAIR_SATURATION_ERROR_REGISTER_IN,
  // Converter side
  input wire [11:0] INTEGER_DECIMATION_RATIO_OUT,
  input wire [15:0] FRACTIONAL_DECIMATION_RATIO_OUT,
  input wire        RATIO_LOADED_OUT,
  input wire        INIT_DONE_OUT
);
  logic [7:0] ch_any;
  logic       any_err;
  logic [7:0] rst_cnt_q;
  // -----------------------------------------------------------------
  // Helper logic
  // -----------------------------------------------------------------
  // Locator and global bits expected from the raw error sources
  always_comb begin
    for (int n = 0; n < 8; n++) ch_any[n] = |PER_CHANNEL_ERROR_REGISTER_IN[8*n +: 8];
    any_err = |{PER_CHANNEL_ERROR_REGISTER_IN, GENERAL_ERROR_REGISTER_ONE_IN,
                GENERAL_ERROR_REGISTER_TWO_IN, PAIR_SATURATION_ERROR_REGISTER_IN};
  end
  // Edges since reset release; saturates so a long run never wraps
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) rst_cnt_q <= 8'h00;
    else if (rst_cnt_q != 8'hFF) rst_cnt_q <= rst_cnt_q + 8'h01;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_rdata_idle;
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_global;
    REG_RD_IN && REG_ADDR_IN >= `ADDR_FAULT_SUMMARY_A && REG_ADDR_IN <= `ADDR_FAULT_SUMMARY_C
      |=> REG_RDATA_OUT[7:5] == {2'b00, $past(any_err)};
  endproperty
  a_global: assert property (p_global) else $error("global fault bit wrong");
  property p_chan_a;
    REG_RD_IN && REG_ADDR_IN == `ADDR_FAULT_SUMMARY_A |=> REG_RDATA_OUT[4:0] == $past(ch_any[4:0]);
  endproperty
  a_chan_a: assert property (p_chan_a) else $error("channel locator wrong");
  property p_res_high;
    REG_RD_IN && REG_ADDR_IN == `ADDR_DECIM_RATIO_HIGH |=> REG_RDATA_OUT[7:4] == 4'h0;
  endproperty
  a_res_high: assert property (p_res_high) else $error("ratio high reserved bits set");
  property p_stable;
    !RATIO_LOADED_OUT |-> $stable(INTEGER_DECIMATION_RATIO_OUT)
      && $stable(FRACTIONAL_DECIMATION_RATIO_OUT);
  endproperty
  a_stable: assert property (p_stable) else $error("active ratio moved without load");
  property p_load_reg;
    REG_WR_IN && REG_ADDR_IN == `ADDR_RESAMPLER_LOAD_CTRL && REG_WDATA_IN == 8'h01
      |-> ##2 RATIO_LOADED_OUT;
  endproperty
  a_load_reg: assert property (p_load_reg) else $error("register load not applied");
  property p_init_wait;
    rst_cnt_q < INIT_CYCLES |-> !INIT_DONE_OUT;
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("init done too early");
  property p_init_done;
    rst_cnt_q >= INIT_CYCLES |-> INIT_DONE_OUT;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init done missing");
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the fault summary and resampler register bank
`timescale 1ns/1ns
`include "fault_bank_regs.vh"
module tb_top;
  localparam INIT_N = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [63:0] per_err = 64'h0;
  logic [7:0]  gen1_err = 8'h00;
  logic [7:0]  gen2_err = 8'h00;
  logic [31:0] sat_err = 32'h0;
  logic        ext = 1'b0;
  wire  [7:0]  rdata;
  wire  [11:0] int_ratio;
  wire  [15:0] frac_ratio;
  wire         loaded;
  wire         init_done;
  wire         irq;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  // Small fuse time keeps the run short
  fault_summary_bank #(.INIT_CYCLES(INIT_N)) u_dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr_en), .REG_RD_IN(rd_en), .REG_RDATA_OUT(rdata),
    .PER_CHANNEL_ERROR_REGISTER_IN(per_err), .GENERAL_ERROR_REGISTER_ONE_IN(gen1_err),
    .GENERAL_ERROR_REGISTER_TWO_IN(gen2_err), .PAIR_SATURATION_ERROR_REGISTER_IN(sat_err),
    .EXT_UPDATE_IN(ext), .INTEGER_DECIMATION_RATIO_OUT(int_ratio),
    .FRACTIONAL_DECIMATION_RATIO_OUT(frac_ratio), .RATIO_LOADED_OUT(loaded),
    .INIT_DONE_OUT(init_done), .IRQ_OUT(irq));
  always #5 clk = ~clk;
  // -----------------------------------------------------------------
  // Bus tasks and comparison
  // -----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Load pulse lasts one cycle, so look every cycle under a bound
  task automatic wait_load;
    int n;
    n = 0;
    while (loaded !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n < 20, 16'h0001);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  // -----------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------
  initial begin
    logic [7:0] ea, eb, ec;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk({4'h0, int_ratio}, 16'h0080);
    chk(frac_ratio, 16'h0000);
    rdc(`ADDR_FAULT_SUMMARY_C, 8'h00);
    rdc(`ADDR_DECIM_RATIO_HIGH, 8'h00);
    rdc(`ADDR_DECIM_RATIO_LOW, 8'h80);
    rdc(`ADDR_DECIM_FRACTION_HIGH, 8'h00);
    rdc(`ADDR_DECIM_FRACTION_LOW, 8'h00);
    rdc(`ADDR_RESAMPLER_LOAD_CTRL, 8'h00);
    rdc(12'h065, 8'h00);
    repeat (INIT_N + 2) @(posedge clk);
    chk(init_done, 16'h0001);
    rdc(`ADDR_FAULT_SUMMARY_C, 8'h10);
    $display("test reset done");
    // One error source at a time; summary writes must be ignored
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      per_err  <= (i < 8) ? 64'h1 << (9 * i) : 64'h0;
      sat_err  <= (i inside {[8:11]}) ? 32'h80 << (8 * (i - 8)) : 32'h0;
      gen1_err <= (i == 12) ? 8'h20 : 8'h00;
      gen2_err <= (i == 13) ? 8'h01 : 8'h00;
      ea = (i < 5) ? 8'h20 | (8'h01 << i) : 8'h20;
      eb = (i inside {[5:7]}) ? 8'h20 | (8'h01 << (i - 5)) : (i == 12) ? 8'h28 : 8'h20;
      eb = (i == 13) ? 8'h30 : eb;
      ec = (i inside {[8:11]}) ? 8'h30 | (8'h01 << (i - 8)) : 8'h30;
      wr(`ADDR_FAULT_SUMMARY_A + i % 3, 8'hFF);
      rdc(`ADDR_FAULT_SUMMARY_A, ea);
      rdc(`ADDR_FAULT_SUMMARY_B, eb);
      rdc(`ADDR_FAULT_SUMMARY_C, ec);
    end
    @(posedge clk);
    gen2_err <= 8'h00;
    rdc(`ADDR_FAULT_SUMMARY_B, 8'h00);
    $display("test fault summary done");
    wr(`ADDR_DECIM_RATIO_HIGH, 8'hFF);
    wr(`ADDR_DECIM_RATIO_LOW, 8'h34);
    wr(`ADDR_DECIM_FRACTION_HIGH, 8'hAB);
    wr(`ADDR_DECIM_FRACTION_LOW, 8'hCD);
    rdc(`ADDR_DECIM_RATIO_HIGH, 8'h0F);
    rdc(`ADDR_DECIM_FRACTION_HIGH, 8'hAB);
    rdc(`ADDR_DECIM_FRACTION_LOW, 8'hCD);
    chk({4'h0, int_ratio}, 16'h0080);
    wr(`ADDR_RESAMPLER_LOAD_CTRL, 8'h01);
    wait_load;
    chk({4'h0, int_ratio}, 16'h0F34);
    chk(frac_ratio, 16'hABCD);
    rdc(`ADDR_RESAMPLER_LOAD_CTRL, 8'h00);
    $display("test register load done");
    // External origin: register bit must no longer load
    wr(`ADDR_RESAMPLER_LOAD_CTRL, 8'hFE);
    rdc(`ADDR_RESAMPLER_LOAD_CTRL, 8'h80);
    wr(`ADDR_DECIM_RATIO_HIGH, 8'h01);
    wr(`ADDR_RESAMPLER_LOAD_CTRL, 8'h81);
    repeat (6) @(posedge clk);
    chk({4'h0, int_ratio}, 16'h0F34);
    @(posedge clk);
    ext <= 1'b1;
    wait_load;
    @(posedge clk);
    ext <= 1'b0;
    chk({4'h0, int_ratio}, 16'h0134);
    wr(`ADDR_RESAMPLER_LOAD_CTRL, 8'h00);
    $display("test external load done");
    // Fault rise, init done and load have all been flagged by now
    rdc(`ADDR_IRQ_STATUS, 8'h07);
    chk(irq, 16'h0000);
    wr(`ADDR_IRQ_MASK, 8'h04);
    @(posedge clk);
    #1 chk(irq, 16'h0001);
    wr(`ADDR_IRQ_STATUS, 8'h04);
    @(posedge clk);
    #1 chk(irq, 16'h0000);
    rdc(`ADDR_IRQ_STATUS, 8'h03);
    $display("test interrupt done");
    test_done();
  end
endmodule
bind fault_summary_bank fault_bank_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .PER_CHANNEL_ERROR_REGISTER_IN(PER_CHANNEL_ERROR_REGISTER_IN),
  .GENERAL_ERROR_REGISTER_ONE_IN(GENERAL_ERROR_REGISTER_ONE_IN),
  .GENERAL_ERROR_REGISTER_TWO_IN(GENERAL_ERROR_REGISTER_TWO_IN),
  .PAIR_SATURATION_ERROR_REGISTER_IN(PAIR_SATURATION_ERROR_REGISTER_IN),
  .INTEGER_DECIMATION_RATIO_OUT(INTEGER_DECIMATION_RATIO_OUT),
  .FRACTIONAL_DECIMATION_RATIO_OUT(FRACTIONAL_DECIMATION_RATIO_OUT),
  .RATIO_LOADED_OUT(RATIO_LOADED_OUT), .INIT_DONE_OUT(INIT_DONE_OUT));
